// *** src/flash_block_service_sequencer.v ***
`timescale 1ns/1ps
`include "flash_seq_consts.vh"
module flash_block_service_sequencer #(
  parameter [8:0] NUM_BLOCKS = 9'h080,
  parameter [1:0] TOP_MACRO = 2'h0,
  // arbitrary value: upper byte family, lower byte revision
  parameter [15:0] DIE_ID = 16'h5a01,
  // arbitrary value
  parameter [7:0] REV_COUNT = 8'h00,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire call_in,
  input wire [7:0] func_code_in,
  input wire [7:0] stack_ptr_in,
  input wire romx_req_in,
  input wire [13:0] romx_addr_in,
  input wire [7:0] sram_rdata_in,
  input wire [7:0] flash_rdata_in,
  output wire busy_out,
  output wire done_out,
  output wire halt_out,
  output wire [7:0] acc_out,
  output wire [7:0] index_out,
  output wire romx_valid_out,
  output wire [7:0] romx_data_out,
  output wire [7:0] sram_addr_out,
  output wire sram_rd_out,
  output wire sram_wr_out,
  output wire [7:0] sram_wdata_out,
  output wire [13:0] flash_addr_out,
  output wire [1:0] flash_row_out,
  output wire [1:0] flash_macro_out,
  output wire flash_rd_out,
  output wire [2:0] flash_cmd_out,
  output wire [7:0] flash_wdata_out
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [13:0] S_IDLE = 14'h0001;
  localparam [13:0] S_PARM = 14'h0002;
  localparam [13:0] S_CHECK = 14'h0004;
  localparam [13:0] S_PCHK = 14'h0008;
  localparam [13:0] S_WXFER = 14'h0010;
  localparam [13:0] S_ERASE = 14'h0020;
  localparam [13:0] S_PROT = 14'h0040;
  localparam [13:0] S_FULL = 14'h0080;
  localparam [13:0] S_TBL = 14'h0100;
  localparam [13:0] S_PULSE = 14'h0200;
  localparam [13:0] S_SETTLE = 14'h0400;
  localparam [13:0] S_WB = 14'h0800;
  localparam [13:0] S_DONE = 14'h1000;
  localparam [13:0] S_HALT = 14'h2000;

  reg [13:0] state_q;
  reg [13:0] ret_q;
  reg [7:0] func_q, sp_q, first_guard_key_q, stack_guard_key_q, blk_q, ptr_q, clk_q, dly_q;
  reg [6:0] idx_q;
  reg [6:0] fill_cnt_q;
  reg fill_act_q;
  reg ph_q;
  reg [2:0] tag_q, tag2_q;
  reg [1:0] fstep_q;
  reg fprot_q;
  reg [1:0] macro_q;
  reg [15:0] pcnt_q;
  reg [8:0] dcnt_q;
  reg [7:0] res_q;
  reg fatal_q;
  reg busy_q, done_q, halt_q;
  reg [7:0] acc_q, x_q;
  reg romx_pend_q, romx_valid_q;
  reg [7:0] romx_data_q;
  reg [7:0] sram_addr_q, sram_wdata_q;
  reg sram_rd_q, sram_wr_q, sram_rdv_q;
  reg [13:0] flash_addr_q;
  reg [1:0] flash_row_q;
  reg flash_rd_q, flash_rdv_q;
  reg [2:0] flash_cmd_q;
  reg [7:0] flash_wdata_q;
  wire [1:0] level;
  wire fifo_in_ready, fifo_out_valid, fifo_pop, fifo_push;
  wire [7:0] fifo_data;

  assign busy_out = busy_q;
  assign done_out = done_q;
  assign halt_out = halt_q;
  assign acc_out = acc_q;
  assign index_out = x_q;
  assign romx_valid_out = romx_valid_q;
  assign romx_data_out = romx_data_q;
  assign sram_addr_out = sram_addr_q;
  assign sram_rd_out = sram_rd_q;
  assign sram_wr_out = sram_wr_q;
  assign sram_wdata_out = sram_wdata_q;
  assign flash_addr_out = flash_addr_q;
  assign flash_row_out = flash_row_q;
  assign flash_macro_out = macro_q;
  assign flash_rd_out = flash_rd_q;
  assign flash_cmd_out = flash_cmd_q;
  assign flash_wdata_out = flash_wdata_q;

  assign level = flash_rdata_in[{blk_q[1:0], 1'b0} +: 2];

  // ----------------------------------------
  // write data buffer
  // ----------------------------------------
  // the sram reader runs during program pulses, so the buffer really fills
  assign fifo_push = fill_act_q && sram_rdv_q;
  assign fifo_pop = (state_q == S_WXFER) && fifo_out_valid && (idx_q < `BLOCK_BYTES);

  sync_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) write_buf (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(sram_rdata_in),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_data)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= S_IDLE;
      ret_q <= S_IDLE;
      func_q <= `BYTE_ZERO;
      sp_q <= `BYTE_ZERO;
      first_guard_key_q <= `BYTE_ZERO;
      stack_guard_key_q <= `BYTE_ZERO;
      blk_q <= `BYTE_ZERO;
      ptr_q <= `BYTE_ZERO;
      clk_q <= `BYTE_ZERO;
      dly_q <= `BYTE_ZERO;
      idx_q <= 7'h00;
      fill_cnt_q <= 7'h00;
      fill_act_q <= 1'b0;
      ph_q <= 1'b0;
      tag_q <= 3'h0;
      tag2_q <= 3'h0;
      fstep_q <= 2'h0;
      fprot_q <= 1'b0;
      macro_q <= 2'h0;
      pcnt_q <= 16'h0000;
      dcnt_q <= 9'h000;
      res_q <= `RC_OK;
      fatal_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      halt_q <= 1'b0;
      acc_q <= `BYTE_ZERO;
      x_q <= `BYTE_ZERO;
      romx_pend_q <= 1'b0;
      romx_valid_q <= 1'b0;
      romx_data_q <= `BYTE_ZERO;
      sram_addr_q <= `BYTE_ZERO;
      sram_wdata_q <= `BYTE_ZERO;
      sram_rd_q <= 1'b0;
      sram_wr_q <= 1'b0;
      sram_rdv_q <= 1'b0;
      flash_addr_q <= 14'h0000;
      flash_row_q <= `ROW_USER;
      flash_rd_q <= 1'b0;
      flash_rdv_q <= 1'b0;
      flash_cmd_q <= `CMD_NONE;
      flash_wdata_q <= `BYTE_ZERO;
    end else begin
      sram_rd_q <= 1'b0;
      sram_wr_q <= 1'b0;
      flash_rd_q <= 1'b0;
      done_q <= 1'b0;
      romx_valid_q <= 1'b0;
      sram_rdv_q <= sram_rd_q;
      flash_rdv_q <= flash_rd_q;
      tag2_q <= tag_q;
      // parameter bytes land one cycle after the read strobe
      if (sram_rdv_q && !fill_act_q) begin
        case (tag2_q)
          3'h0: first_guard_key_q <= sram_rdata_in;
          3'h1: stack_guard_key_q <= sram_rdata_in;
          3'h2: blk_q <= sram_rdata_in;
          3'h3: ptr_q <= sram_rdata_in;
          3'h4: clk_q <= sram_rdata_in;
          3'h6: dly_q <= sram_rdata_in;
          default: ;
        endcase
      end
      if (fill_act_q && !sram_rd_q && !sram_rdv_q && fifo_in_ready) begin
        if (fill_cnt_q < `BLOCK_BYTES) begin
          sram_rd_q <= 1'b1;
          sram_addr_q <= ptr_q + {1'b0, fill_cnt_q};
          fill_cnt_q <= fill_cnt_q + 7'h01;
        end else begin
          fill_act_q <= 1'b0;
        end
      end
      if (romx_pend_q && flash_rdv_q) begin
        romx_pend_q <= 1'b0;
        romx_valid_q <= 1'b1;
        romx_data_q <= flash_rdata_in;
      end
      case (state_q)
        S_IDLE: begin
          if (call_in) begin
            func_q <= func_code_in;
            sp_q <= stack_ptr_in;
            busy_q <= 1'b1;
            idx_q <= 7'h00;
            state_q <= S_PARM;
          end else if (romx_req_in && !romx_pend_q) begin
            flash_rd_q <= 1'b1;
            flash_row_q <= `ROW_USER;
            flash_addr_q <= romx_addr_in;
            romx_pend_q <= 1'b1;
          end
        end
        S_PARM: begin
          if (idx_q[2:0] < `PB_COUNT) begin
            sram_rd_q <= 1'b1;
            sram_addr_q <= `PB_FIRST_GUARD_KEY + {5'h00, idx_q[2:0]};
            tag_q <= idx_q[2:0];
            idx_q <= idx_q + 7'h01;
          end else if (!sram_rd_q && !sram_rdv_q) begin
            state_q <= S_CHECK;
          end
        end
        S_CHECK: begin
          idx_q <= 7'h00;
          ph_q <= 1'b0;
          fatal_q <= 1'b0;
          if (first_guard_key_q != `FIRST_GUARD_KEY_VAL || stack_guard_key_q != sp_q) begin
            state_q <= S_HALT;
          end else begin
            case (func_q)
              `FN_WRITE, `FN_ERASE: begin
                if ({1'b0, blk_q} >= NUM_BLOCKS) begin
                  res_q <= `RC_FATAL;
                  fatal_q <= 1'b1;
                  state_q <= S_WB;
                end else begin
                  state_q <= S_PCHK;
                end
              end
              `FN_PROTECT: state_q <= S_PROT;
              `FN_FULL: begin
                fstep_q <= 2'h0;
                fprot_q <= 1'b0;
                macro_q <= TOP_MACRO;
                state_q <= S_FULL;
              end
              `FN_TABLE: state_q <= S_TBL;
              default: state_q <= S_HALT;
            endcase
          end
        end
        S_PCHK: begin
          if (!ph_q) begin
            flash_rd_q <= 1'b1;
            flash_row_q <= `ROW_PROT;
            flash_addr_q <= {8'h00, blk_q[7:2]};
            ph_q <= 1'b1;
          end else if (flash_rdv_q) begin
            ph_q <= 1'b0;
            if (level == `LVL_NO_IW) begin
              res_q <= `RC_PROT;
              state_q <= S_WB;
            end else if (func_q == `FN_WRITE) begin
              fill_act_q <= 1'b1;
              fill_cnt_q <= 7'h00;
              state_q <= S_WXFER;
            end else begin
              state_q <= S_ERASE;
            end
          end
        end
        S_WXFER: begin
          // program one buffered byte per pulse
          if (idx_q >= `BLOCK_BYTES) begin
            res_q <= `RC_OK;
            state_q <= S_WB;
          end else if (fifo_out_valid) begin
            flash_row_q <= `ROW_USER;
            flash_addr_q <= {blk_q, idx_q[5:0]};
            flash_wdata_q <= fifo_data;
            flash_cmd_q <= `CMD_PROG;
            idx_q <= idx_q + 7'h01;
            ret_q <= S_WXFER;
            state_q <= S_PULSE;
          end
        end
        S_ERASE: begin
          flash_row_q <= `ROW_USER;
          flash_addr_q <= {blk_q, 6'h00};
          flash_cmd_q <= `CMD_ERASE_BLK;
          res_q <= `RC_OK;
          ret_q <= S_WB;
          state_q <= S_PULSE;
        end
        S_PROT: begin
          if (idx_q >= `BLOCK_BYTES) begin
            res_q <= `RC_OK;
            state_q <= S_WB;
          end else if (!ph_q) begin
            sram_rd_q <= 1'b1;
            sram_addr_q <= `PROT_SRC + {1'b0, idx_q};
            tag_q <= 3'h7;
            flash_rd_q <= 1'b1;
            flash_row_q <= `ROW_PROT;
            flash_addr_q <= {8'h00, idx_q[5:0]};
            ph_q <= 1'b1;
          end else if (flash_rdv_q) begin
            flash_wdata_q <= flash_rdata_in | sram_rdata_in;
            flash_cmd_q <= `CMD_PROG;
            idx_q <= idx_q + 7'h01;
            ph_q <= 1'b0;
            ret_q <= S_PROT;
            state_q <= S_PULSE;
          end
        end
        S_FULL: begin
          ret_q <= S_FULL;
          if (!fprot_q) begin
            // erase, bulk zero, erase per macro
            fstep_q <= fstep_q + 2'h1;
            flash_row_q <= `ROW_USER;
            case (fstep_q)
              2'h1: begin
                flash_cmd_q <= `CMD_BULK_ZERO;
                state_q <= S_PULSE;
              end
              2'h3: begin
                fstep_q <= 2'h0;
                if (macro_q == 2'h0) begin
                  fprot_q <= 1'b1;
                  macro_q <= TOP_MACRO;
                end else begin
                  macro_q <= macro_q - 2'h1;
                end
              end
              default: begin
                flash_cmd_q <= `CMD_ERASE_USER;
                state_q <= S_PULSE;
              end
            endcase
          end else if (fstep_q == 2'h0) begin
            flash_row_q <= `ROW_PROT;
            flash_cmd_q <= `CMD_ERASE_PROT;
            fstep_q <= 2'h1;
            idx_q <= 7'h00;
            state_q <= S_PULSE;
          end else if (idx_q < `BLOCK_BYTES) begin
            flash_addr_q <= {8'h00, idx_q[5:0]};
            flash_wdata_q <= `BYTE_ZERO;
            flash_cmd_q <= `CMD_PROG;
            idx_q <= idx_q + 7'h01;
            state_q <= S_PULSE;
          end else if (macro_q == 2'h0) begin
            res_q <= `RC_OK;
            state_q <= S_WB;
          end else begin
            macro_q <= macro_q - 2'h1;
            fstep_q <= 2'h0;
          end
        end
        S_TBL: begin
          if (idx_q >= `TBL_BYTES) begin
            case (blk_q[2:0])
              3'h0: begin
                acc_q <= DIE_ID[7:0];
                x_q <= DIE_ID[15:8];
              end
              3'h1: begin
                acc_q <= REV_COUNT;
                x_q <= `BYTE_ALL;
              end
              default: begin
                acc_q <= `BYTE_ALL;
                x_q <= `BYTE_ALL;
              end
            endcase
            state_q <= S_DONE;
          end else if (!ph_q) begin
            // low three bits pick the table
            flash_rd_q <= 1'b1;
            flash_row_q <= `ROW_TABLE;
            flash_addr_q <= {8'h00, blk_q[2:0], idx_q[2:0]};
            ph_q <= 1'b1;
          end else if (flash_rdv_q) begin
            sram_wr_q <= 1'b1;
            sram_addr_q <= `PB_FIRST_GUARD_KEY + {5'h00, idx_q[2:0]};
            sram_wdata_q <= flash_rdata_in;
            idx_q <= idx_q + 7'h01;
            ph_q <= 1'b0;
          end
        end
        S_PULSE: begin
          if (pcnt_q == 16'h0000) begin
            pcnt_q <= ({8'h00, clk_q} + 16'h0001) << `PULSE_SHIFT;
          end else if (pcnt_q == 16'h0001) begin
            pcnt_q <= 16'h0000;
            flash_cmd_q <= `CMD_NONE;
            dcnt_q <= {1'b0, dly_q} + 9'h001;
            state_q <= S_SETTLE;
          end else begin
            pcnt_q <= pcnt_q - 16'h0001;
          end
        end
        S_SETTLE: begin
          if (dcnt_q <= 9'h001) begin
            dcnt_q <= 9'h000;
            state_q <= ret_q;
          end else begin
            dcnt_q <= dcnt_q - 9'h001;
          end
        end
        S_WB: begin
          // result into first key, second key cleared
          sram_wr_q <= 1'b1;
          if (!ph_q) begin
            sram_addr_q <= `PB_FIRST_GUARD_KEY;
            sram_wdata_q <= res_q;
            ph_q <= 1'b1;
          end else begin
            sram_addr_q <= `PB_STACK_GUARD_KEY;
            sram_wdata_q <= `BYTE_ZERO;
            acc_q <= `BYTE_ZERO;
            ph_q <= 1'b0;
            state_q <= fatal_q ? S_HALT : S_DONE;
          end
        end
        S_DONE: begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          state_q <= S_IDLE;
        end
        S_HALT: begin
          // held until reset; requests stay ignored
          halt_q <= 1'b1;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // flash_block_service_sequencer

// *** src/flash_seq_consts.vh ***
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH
// ----------------------------------------
// parameter block in sram
// ----------------------------------------
`define PB_FIRST_GUARD_KEY 8'hf8
`define PB_STACK_GUARD_KEY 8'hf9
`define PB_BLOCK 8'hfa
`define PB_PTR 8'hfb
`define PB_CLOCK 8'hfc
`define PB_DELAY 8'hfe
`define PB_COUNT 3'h7
`define PROT_SRC 8'h80
`define FIRST_GUARD_KEY_VAL 8'h3a
// ----------------------------------------
// function and result codes
// ----------------------------------------
`define FN_WRITE 8'h02
`define FN_ERASE 8'h03
`define FN_PROTECT 8'h04
`define FN_FULL 8'h05
`define FN_TABLE 8'h06
`define RC_OK 8'h00
`define RC_PROT 8'h01
`define RC_FATAL 8'h03
`define BYTE_ZERO 8'h00
`define BYTE_ALL 8'hff
// ----------------------------------------
// sizes and levels
// ----------------------------------------
`define BLOCK_BYTES 7'h40
`define TBL_BYTES 7'h08
`define LVL_NO_IW 2'h3
`define PULSE_SHIFT 2
// ----------------------------------------
// flash macro commands and rows
// ----------------------------------------
`define CMD_NONE 3'h0
`define CMD_PROG 3'h1
`define CMD_ERASE_BLK 3'h2
`define CMD_ERASE_USER 3'h3
`define CMD_BULK_ZERO 3'h4
`define CMD_ERASE_PROT 3'h5
`define ROW_USER 2'h0
`define ROW_PROT 2'h1
`define ROW_TABLE 2'h2
`endif

// *** src/sync_fifo.v ***
`timescale 1ns/1ps
module sync_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wr_ptr_q;
  reg [AW:0] rd_ptr_q;
  wire full;
  wire empty;

  // extra pointer bit tells full from empty
  assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_q[rd_ptr_q[AW-1:0]];

  always @(posedge ref_clk_in) begin
    if (in_valid_in && !full) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data_in;
    end
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= {(AW+1){1'b0}};
      rd_ptr_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid_in && !full) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (out_ready_in && !empty) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule // sync_fifo

// *** dv/flash_seq_assertions.sv ***
`timescale 1ns/1ps
module flash_seq_assertions (
  input wire ref_clk_in,
  input wire rst_in,
  input wire call_in,
  input wire romx_req_in,
  input wire [7:0] sram_rdata_in,
  input wire busy_out,
  input wire done_out,
  input wire halt_out,
  input wire romx_valid_out,
  input wire [7:0] sram_addr_out,
  input wire sram_rd_out,
  input wire sram_wr_out,
  input wire [7:0] sram_wdata_out,
  input wire [1:0] flash_row_out,
  input wire [2:0] flash_cmd_out
);
  logic fc_q;
  logic [7:0] clk_q;
  logic [10:0] run_q;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // --------------------------------
  // clock divider seen on the bus
  // --------------------------------
  // the divider is learnt from the sram answer so the pulse check needs no tap into the body
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      fc_q <= 1'b0;
      clk_q <= 8'h00;
      run_q <= 11'h000;
    end else begin
      fc_q <= sram_rd_out && sram_addr_out == 8'hfc;
      if (fc_q) begin
        clk_q <= sram_rdata_in;
      end
      run_q <= (flash_cmd_out != 3'h0) ? run_q + 11'h001 : 11'h000;
    end
  end
  // --------------------------------
  // properties
  // --------------------------------
  a_call_taken: assert property (call_in && !busy_out |=> busy_out ##1 (sram_rd_out && sram_addr_out == 8'hf8))
    else $error("call not taken");
  a_done_pulse: assert property (done_out |-> !busy_out ##1 !done_out)
    else $error("done not a single pulse");
  a_idle_quiet: assert property (!busy_out |-> flash_cmd_out == 3'h0 && !sram_wr_out)
    else $error("activity while idle");
  // the pulse counter loads a cycle after the command rises, so the command stands one cycle longer
  a_pulse_len: assert property ($fell(flash_cmd_out != 3'h0) |->
    run_q == (({3'h0, clk_q} + 11'h001) << 2) + 11'h001)
    else $error("pulse length wrong");
  a_no_hidden: assert property (flash_cmd_out != 3'h0 |-> flash_row_out < 2'h2)
    else $error("command on hidden row");
  a_romx_served: assert property (romx_req_in && !call_in && !busy_out |-> ##[1:4] romx_valid_out)
    else $error("indexed read not served");
  a_refuse_wb: assert property (sram_wr_out && sram_addr_out == 8'hf8 && sram_wdata_out == 8'h01
    |=> sram_wr_out && sram_addr_out == 8'hf9 && sram_wdata_out == 8'h00)
    else $error("refusal write-back wrong");
  a_halt_sticky: assert property (halt_out |=> halt_out && busy_out && !done_out)
    else $error("halt released");
endmodule // flash_seq_assertions
bind flash_block_service_sequencer flash_seq_assertions i_chk (.ref_clk_in, .rst_in, .call_in, .romx_req_in,
  .sram_rdata_in, .busy_out, .done_out, .halt_out, .romx_valid_out, .sram_addr_out, .sram_rd_out,
  .sram_wr_out, .sram_wdata_out, .flash_row_out, .flash_cmd_out);

// *** dv/mem_model.sv ***
`timescale 1ns/1ps
module mem_model (
  input wire ref_clk_in,
  input wire [7:0] sram_addr_in,
  input wire sram_rd_in,
  input wire sram_wr_in,
  input wire [7:0] sram_wdata_in,
  output logic [7:0] sram_rdata_out,
  input wire [13:0] flash_addr_in,
  input wire [1:0] flash_row_in,
  input wire flash_rd_in,
  input wire [2:0] flash_cmd_in,
  input wire [7:0] flash_wdata_in,
  output logic [7:0] flash_rdata_out
);
  logic [7:0] sram [0:255];
  logic [7:0] user [0:16383];
  logic [7:0] prot [0:63];
  logic [7:0] tbl [0:63];
  wire [7:0] fbyte = flash_row_in == 2'h0 ? user[flash_addr_in] :
    flash_row_in == 2'h1 ? prot[flash_addr_in[5:0]] : tbl[flash_addr_in[5:0]];
  initial begin
    sram_rdata_out = 8'h00;
    flash_rdata_out = 8'h00;
  end
  // idle read lines toggle so a stale byte never passes for fresh data
  always @(posedge ref_clk_in) begin
    if (sram_wr_in) begin
      sram[sram_addr_in] <= sram_wdata_in;
    end
    sram_rdata_out <= sram_rd_in ? sram[sram_addr_in] : ~sram_rdata_out;
    flash_rdata_out <= flash_rd_in ? fbyte : ~flash_rdata_out;
    case (flash_cmd_in)
      3'h1: begin
        if (flash_row_in == 2'h1) prot[flash_addr_in[5:0]] <= flash_wdata_in;
        else user[flash_addr_in] <= flash_wdata_in;
      end
      3'h2: for (int i = 0; i < 64; i++) user[{flash_addr_in[13:6], i[5:0]}] <= 8'hff;
      3'h3: for (int i = 0; i < 16384; i++) user[i] <= 8'hff;
      3'h4: for (int i = 0; i < 16384; i++) user[i] <= 8'h00;
      3'h5: for (int i = 0; i < 64; i++) prot[i] <= 8'hff;
      default: ;
    endcase
  end
endmodule // mem_model

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`include "flash_seq_consts.vh"
module testbench;
  localparam [15:0] die_id = 16'h5a01; // arbitrary value
  localparam [7:0] rev_cnt = 8'h00; // arbitrary value
  localparam [7:0] sp = 8'h47;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic call_in = 1'b0;
  logic [7:0] func_code_in = 8'h00;
  logic romx_req_in = 1'b0;
  logic [13:0] romx_addr_in = 14'h0000;
  wire busy_out, done_out, halt_out, romx_valid_out, sram_rd_out, sram_wr_out, flash_rd_out;
  wire [7:0] acc_out, index_out, romx_data_out, sram_addr_out, sram_wdata_out, flash_wdata_out;
  wire [7:0] sram_rdata_in, flash_rdata_in;
  wire [13:0] flash_addr_out;
  wire [1:0] flash_row_out, flash_macro_out;
  wire [2:0] flash_cmd_out;
  int fails = 0;
  int cmp_count = 0;
  always #20 ref_clk_in = ~ref_clk_in;
  flash_block_service_sequencer #(.NUM_BLOCKS(9'h080), .DIE_ID(die_id), .REV_COUNT(rev_cnt)) i_dut (
    .ref_clk_in, .rst_in, .call_in, .func_code_in, .stack_ptr_in(sp), .romx_req_in, .romx_addr_in,
    .sram_rdata_in, .flash_rdata_in, .busy_out, .done_out, .halt_out, .acc_out, .index_out,
    .romx_valid_out, .romx_data_out, .sram_addr_out, .sram_rd_out, .sram_wr_out, .sram_wdata_out,
    .flash_addr_out, .flash_row_out, .flash_macro_out, .flash_rd_out, .flash_cmd_out, .flash_wdata_out);
  mem_model p (.ref_clk_in, .sram_addr_in(sram_addr_out), .sram_rd_in(sram_rd_out), .sram_wr_in(sram_wr_out),
    .sram_wdata_in(sram_wdata_out), .sram_rdata_out(sram_rdata_in), .flash_addr_in(flash_addr_out),
    .flash_row_in(flash_row_out), .flash_rd_in(flash_rd_out), .flash_cmd_in(flash_cmd_out),
    .flash_wdata_in(flash_wdata_out), .flash_rdata_out(flash_rdata_in));
  // --------------------------------
  // shared tasks
  // --------------------------------
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task do_reset;
    rst_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    rst_in = 1'b0;
  endtask
  task params(input logic [7:0] k1, input logic [7:0] blk, input logic [7:0] ptr);
    p.sram[8'hf8] = k1;
    p.sram[8'hf9] = sp;
    p.sram[8'hfa] = blk;
    p.sram[8'hfb] = ptr;
    p.sram[8'hfc] = 8'h01;
    p.sram[8'hfe] = 8'h01;
  endtask
  task start(input logic [7:0] fc);
    @(negedge ref_clk_in);
    call_in = 1'b1;
    func_code_in = fc;
    @(negedge ref_clk_in);
    call_in = 1'b0;
  endtask
  task finish_op;
    int n;
    n = 0;
    while (done_out !== 1'b1 && halt_out !== 1'b1 && n < 8000) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk("op_end", (n < 8000) ? 8'h01 : 8'h00, 8'h01);
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task s_write;
    for (int i = 0; i < 64; i++) p.sram[8'h10 + i[7:0]] = 8'ha5 ^ i[7:0];
    params(`FIRST_GUARD_KEY_VAL, 8'h05, 8'h10);
    start(`FN_WRITE);
    repeat (3) @(negedge ref_clk_in);
    start(`FN_FULL);
    finish_op;
    for (int i = 0; i < 64; i++) chk("wr_byte", p.user[{8'h05, i[5:0]}], 8'ha5 ^ i[7:0]);
    chk("wr_next", p.user[14'h0180], 8'hff);
    chk("wr_rc", p.sram[8'hf8], `RC_OK);
    chk("wr_stack_guard_key", p.sram[8'hf9], 8'h00);
  endtask
  task s_refuse;
    int n;
    p.prot[1] = 8'hb4;
    params(`FIRST_GUARD_KEY_VAL, 8'h06, 8'h10);
    start(`FN_WRITE);
    finish_op;
    chk("rf_rc", p.sram[8'hf8], `RC_PROT);
    chk("rf_acc", acc_out, 8'h00);
    chk("rf_data", p.user[14'h0180], 8'hff);
    @(negedge ref_clk_in);
    romx_req_in = 1'b1;
    romx_addr_in = {8'h05, 6'h03};
    n = 0;
    while (romx_valid_out !== 1'b1 && n < 20) begin
      @(negedge ref_clk_in);
      n++;
    end
    romx_req_in = 1'b0;
    chk("romx", romx_data_out, 8'ha6);
    params(`FIRST_GUARD_KEY_VAL, 8'h05, 8'h10);
    start(`FN_ERASE);
    finish_op;
    chk("er_lo", p.user[14'h0140], 8'hff);
    chk("er_hi", p.user[14'h017f], 8'hff);
    chk("er_rc", p.sram[8'hf8], `RC_OK);
    chk("er_prot", p.prot[1], 8'hb4);
    for (int i = 0; i < 64; i++) p.sram[8'h10 + i[7:0]] = 8'h00;
    params(`FIRST_GUARD_KEY_VAL, 8'h05, 8'h10);
    start(`FN_WRITE);
    finish_op;
    chk("wipe", p.user[14'h017f], 8'h00);
  endtask
  task s_protect;
    for (int i = 0; i < 64; i++) p.sram[8'h80 + i[7:0]] = 8'h00;
    p.sram[8'h82] = 8'h03;
    p.prot[2] = 8'h10;
    params(`FIRST_GUARD_KEY_VAL, 8'h00, 8'h00);
    start(`FN_PROTECT);
    finish_op;
    chk("pr_or", p.prot[2], 8'h13);
    chk("pr_keep", p.prot[1], 8'hb4);
  endtask
  task s_table;
    for (int t = 0; t < 8; t++) begin
      params(`FIRST_GUARD_KEY_VAL, 8'hf8 | t[7:0], 8'h00);
      start(`FN_TABLE);
      finish_op;
      for (int i = 0; i < 8; i++) chk("tb_byte", p.sram[8'hf8 + i[7:0]], 8'h40 + t[7:0] * 8'h08 + i[7:0]);
      chk("tb_acc", acc_out, t == 0 ? die_id[7:0] : (t == 1 ? rev_cnt : 8'hff));
      chk("tb_idx", index_out, t == 0 ? die_id[15:8] : 8'hff);
    end
  endtask
  task s_full;
    p.user[0] = 8'h12;
    params(`FIRST_GUARD_KEY_VAL, 8'h00, 8'h00);
    start(`FN_FULL);
    finish_op;
    chk("fe_user", p.user[0], 8'hff);
    chk("fe_prot1", p.prot[1], 8'h00);
    chk("fe_prot2", p.prot[2], 8'h00);
    chk("fe_table", p.tbl[0], 8'h40);
    chk("fe_macro", {6'h00, flash_macro_out}, 8'h00);
  endtask
  task s_fatal;
    logic [7:0] k [3] = '{8'h3b, `FIRST_GUARD_KEY_VAL, `FIRST_GUARD_KEY_VAL};
    logic [7:0] b [3] = '{8'h05, 8'h05, 8'h80};
    logic [7:0] f [3] = '{`FN_WRITE, 8'h07, `FN_WRITE};
    logic [7:0] e [3] = '{8'h3b, `FIRST_GUARD_KEY_VAL, `RC_FATAL};
    for (int c = 0; c < 3; c++) begin
      do_reset;
      params(k[c], b[c], 8'h10);
      start(f[c]);
      finish_op;
      chk("ft_halt", {7'h00, halt_out}, 8'h01);
      chk("ft_rc", p.sram[8'hf8], e[c]);
    end
  endtask
  // --------------------------------
  // main sequence and watchdog
  // --------------------------------
  initial begin
    for (int i = 0; i < 16384; i++) p.user[i] = 8'hff;
    for (int i = 0; i < 64; i++) p.prot[i] = 8'h00;
    for (int i = 0; i < 64; i++) p.tbl[i] = 8'h40 + i[7:0];
    for (int i = 0; i < 256; i++) p.sram[i] = 8'h00;
    do_reset;
    s_write;
    s_table;
    s_refuse;
    s_protect;
    s_full;
    s_fatal;
    print_verdict;
  end
  // about ten times the expected run, well under the cycle budget
  initial begin
    #1600000;
    fails++;
    print_verdict;
  end
endmodule // testbench
